// file: dhp_host_port.sv
// parallel host bus port with register file, reset effects and vectored interrupt
`timescale 1ns/100ps
`include "dhp_duart_port_map.svh"

//Function
// - a low chip select enables byte transfers steered by read/write and the select lines.
// - a high chip select outside an interrupt acknowledge cycle leaves all eight data lines undriven.
// - the four select lines pick which register or port a cycle touches.
// - data line zero carries the least significant bit of each byte.
// - reset clears both status registers, mask, interrupt status, output port and its config.
// - reset loads the interrupt vector with 0f.
// - reset drives all general outputs high and halts the counter/timer.
// - reset makes both channels inactive with their serial outputs at mark.
// - reset clears test modes and points each mode pointer at the first mode register.
// - transfer acknowledge goes low in read and write cycles, and in interrupt acknowledge cycles with an interrupt pending.
// - the open-drain request pulls low while any unmasked interrupt condition holds.
// - an acknowledge with an interrupt pending returns the vector and acknowledges.
module dhp_host_port #(
   parameter int NUM_IRQ = 8
) (
   input  wire logic               i_clk,
   input  wire logic               i_sys_rst,
   input  wire logic               i_ce,
   input  wire logic               i_reset_low_input,
   input  wire logic               i_chip_select_low,
   input  wire logic               i_read_not_write_line,
   input  wire logic [3:0]         i_register_select_lines,
   input  wire logic [7:0]         i_bus_data_lines,
   input  wire logic               i_irq_ack_low,
   input  wire logic [NUM_IRQ-1:0] i_irq_events,
   input  wire logic [7:0]         i_chan_a_status,
   input  wire logic [7:0]         i_chan_b_status,
   input  wire logic [1:0]         i_tx_bit,
   output logic [7:0]              o_bus_data_lines,
   output logic                    o_bus_data_oe,
   output logic                    o_transfer_ack_low,
   output logic                    o_transfer_ack_oe,
   output logic                    o_irq_request_low,
   output logic                    o_irq_request_oe,
   output logic [7:0]              o_general_output_pins,
   output logic [7:0]              o_output_port_config,
   output logic                    o_serial_out_chan_a,
   output logic                    o_serial_out_chan_b,
   output logic [1:0]              o_chan_active,
   output logic                    o_timer_run,
   output logic [7:0]              o_test_mode,
   output logic [15:0]             o_mode_a,
   output logic [15:0]             o_mode_b
);

   // pin synchronisers; first stage feeds only the second
   logic [14:0] pin_s1_r;
   logic [14:0] pin_s2_r;
   wire  [14:0] pin_raw = {i_reset_low_input, i_chip_select_low, i_read_not_write_line,
                           i_irq_ack_low, i_register_select_lines, i_bus_data_lines[6:0]};
   logic        d7_s1_r;
   logic        d7_s2_r;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pin_s1_r <= 15'h7c00;
         pin_s2_r <= 15'h7c00;
         d7_s1_r  <= 1'b0;
         d7_s2_r  <= 1'b0;
      end
      else if (i_ce)
      begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         d7_s1_r  <= i_bus_data_lines[7];
         d7_s2_r  <= d7_s1_r;
      end
   end

   wire       rst_pin_low = ~pin_s2_r[14];
   wire       cs_low      = ~pin_s2_r[13];
   wire       rd_cycle    = pin_s2_r[12];
   wire       iack_low    = ~pin_s2_r[11];
   wire [3:0] sel         = pin_s2_r[10:7];
   wire [7:0] wdata       = {d7_s2_r, pin_s2_r[6:0]};
   wire       rst_all     = i_sys_rst | rst_pin_low;

   // handshake state
   dhp_pkg::dhp_state_e state_r;
   dhp_pkg::dhp_state_e state_nxt;
   logic                is_read_r;
   logic                is_iack_r;

   // register file
   logic [7:0]         stat_a_r;
   logic [7:0]         stat_b_r;
   logic [NUM_IRQ-1:0] isr_r;
   logic [NUM_IRQ-1:0] imr_r;
   logic [7:0]         ivr_r;
   logic [7:0]         opr_r;
   logic [7:0]         output_port_config_reg_r;
   logic [7:0]         test_r;
   logic [7:0]         mode_r [2][2];
   logic [1:0]         mode_ptr_r;
   logic [1:0]         active_r;
   logic               timer_run_r;
   logic [7:0]         rdata_r;
   logic               ack_r;
   logic               oe_r;
   logic [1:0]         txd_r;

   wire irq_pending = |(isr_r & imr_r);
   wire start_bus   = (state_r == dhp_pkg::DHP_IDLE) & cs_low;
   wire start_iack  = (state_r == dhp_pkg::DHP_IDLE) & ~cs_low & iack_low & irq_pending;
   wire do_write    = start_bus & ~rd_cycle;
   wire do_read     = start_bus & rd_cycle;
   wire released    = is_iack_r ? ~iack_low : ~cs_low;

   function automatic logic [7:0] dhp_read_mux(input logic [3:0] a, input logic [7:0] m_a,
                                               input logic [7:0] m_b);
      logic [7:0] v;
      v = `DHP_ZERO_BYTE;
      case (a)
         `DHP_OFS_MODE_A:  v = m_a;
         `DHP_OFS_STAT_A:  v = stat_a_r;
         `DHP_OFS_ISR:     v = 8'(isr_r);
         `DHP_OFS_IMR:     v = 8'(imr_r);
         `DHP_OFS_TEST:    v = test_r;
         `DHP_OFS_MODE_B:  v = m_b;
         `DHP_OFS_STAT_B:  v = stat_b_r;
         `DHP_OFS_OUTPUT_PORT_CONFIG_REG:    v = output_port_config_reg_r;
         `DHP_OFS_IVR:     v = ivr_r;
         `DHP_OFS_OPR_SET: v = opr_r;
         default:          v = `DHP_ZERO_BYTE;
      endcase
      return v;
   endfunction

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         dhp_pkg::DHP_IDLE:
            if (start_bus | start_iack)
               state_nxt = dhp_pkg::DHP_ACCESS;
         dhp_pkg::DHP_ACCESS:
            state_nxt = dhp_pkg::DHP_ACK;
         dhp_pkg::DHP_ACK:
            if (released)
               state_nxt = dhp_pkg::DHP_IDLE;
         default:
            state_nxt = dhp_pkg::DHP_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (rst_all)
      begin
         state_r   <= dhp_pkg::DHP_IDLE;
         is_read_r <= 1'b0;
         is_iack_r <= 1'b0;
         ack_r     <= 1'b0;
         oe_r      <= 1'b0;
         rdata_r   <= `DHP_ZERO_BYTE;
      end
      else if (i_ce)
      begin
         state_r <= state_nxt;
         if (state_r == dhp_pkg::DHP_IDLE)
         begin
            is_read_r <= do_read;
            is_iack_r <= start_iack;
         end
         if (start_iack)
            rdata_r <= ivr_r;
         else if (do_read)
            rdata_r <= dhp_read_mux(sel, mode_r[0][mode_ptr_r[0]], mode_r[1][mode_ptr_r[1]]);
         oe_r  <= (state_nxt != dhp_pkg::DHP_IDLE) & (is_read_r | is_iack_r | do_read | start_iack)
                  & ~(state_r == dhp_pkg::DHP_ACK & released);
         ack_r <= (state_nxt == dhp_pkg::DHP_ACK);
      end
   end

   // per-channel state: mode registers, pointer, enable, serial idle level
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         wire [3:0] mode_ofs = (ch == 0) ? `DHP_OFS_MODE_A : `DHP_OFS_MODE_B;
         wire [3:0] cmd_ofs  = (ch == 0) ? `DHP_OFS_CMD_A : `DHP_OFS_CMD_B;
         wire       mode_hit = start_bus & (sel == mode_ofs);
         wire       cmd_hit  = do_write & (sel == cmd_ofs);
         always_ff @(posedge i_clk)
         begin
            if (rst_all)
            begin
               mode_ptr_r[ch] <= 1'b0;
               mode_r[ch][0]  <= `DHP_ZERO_BYTE;
               mode_r[ch][1]  <= `DHP_ZERO_BYTE;
               active_r[ch]   <= 1'b0;
               txd_r[ch]      <= 1'b1;
            end
            else if (i_ce)
            begin
               if (mode_hit & ~rd_cycle)
                  mode_r[ch][mode_ptr_r[ch]] <= wdata;
               if (cmd_hit & wdata[`DHP_CMD_PTR_RESET])
                  mode_ptr_r[ch] <= 1'b0;
               else if (mode_hit)
                  mode_ptr_r[ch] <= 1'b1;
               if (cmd_hit & wdata[`DHP_CMD_DISABLE])
                  active_r[ch] <= 1'b0;
               else if (cmd_hit & wdata[`DHP_CMD_ENABLE])
                  active_r[ch] <= 1'b1;
               // idle transmitter sits at mark
               txd_r[ch] <= active_r[ch] ? i_tx_bit[ch] : 1'b1;
            end
         end
      end
   endgenerate

   // shared registers and write side effects
   wire       isr_clr_hit = do_write & (sel == `DHP_OFS_ISR);
   wire [NUM_IRQ-1:0] isr_clr = isr_clr_hit ? wdata[NUM_IRQ-1:0] : '0;

   always_ff @(posedge i_clk)
   begin
      if (rst_all)
      begin
         stat_a_r    <= `DHP_ZERO_BYTE;
         stat_b_r    <= `DHP_ZERO_BYTE;
         isr_r       <= '0;
         imr_r       <= '0;
         opr_r       <= `DHP_ZERO_BYTE;
         output_port_config_reg_r      <= `DHP_ZERO_BYTE;
         ivr_r       <= `DHP_IVR_RESET;
         test_r      <= `DHP_ZERO_BYTE;
         timer_run_r <= 1'b0;
      end
      else if (i_ce)
      begin
         stat_a_r <= i_chan_a_status;
         stat_b_r <= i_chan_b_status;
         // new event wins over a same-cycle clear
         isr_r    <= (isr_r & ~isr_clr) | i_irq_events;
         if (do_write)
         begin
            case (sel)
               `DHP_OFS_IMR:     imr_r  <= wdata[NUM_IRQ-1:0];
               `DHP_OFS_TEST:    test_r <= wdata;
               `DHP_OFS_OUTPUT_PORT_CONFIG_REG:    output_port_config_reg_r <= wdata;
               `DHP_OFS_IVR:     ivr_r  <= wdata;
               `DHP_OFS_OPR_SET: opr_r  <= opr_r | wdata;
               `DHP_OFS_OPR_CLR: opr_r  <= opr_r & ~wdata;
               default:          opr_r  <= opr_r;
            endcase
         end
         // reads of DHP_OFS_OPR_CLR and DHP_OFS_TMR_STOP start and stop the timer
         if (do_read & (sel == `DHP_OFS_OPR_CLR))
            timer_run_r <= 1'b1;
         else if (do_read & (sel == `DHP_OFS_TMR_STOP))
            timer_run_r <= 1'b0;
      end
   end

   // drive data only during a read or vector cycle
   assign o_bus_data_lines      = rdata_r;
   assign o_bus_data_oe         = oe_r;
   // ack stays undriven in an acknowledge cycle without a pending interrupt
   assign o_transfer_ack_low    = ~ack_r;
   assign o_transfer_ack_oe     = ack_r;
   assign o_irq_request_low     = 1'b0;
   assign o_irq_request_oe      = irq_pending;
   // pins are the complement of the port register, so all high after reset
   assign o_general_output_pins = ~opr_r;
   assign o_output_port_config  = output_port_config_reg_r;
   assign o_serial_out_chan_a   = txd_r[0];
   assign o_serial_out_chan_b   = txd_r[1];
   assign o_chan_active         = active_r;
   assign o_timer_run           = timer_run_r;
   assign o_test_mode           = test_r;
   assign o_mode_a              = {mode_r[0][1], mode_r[0][0]};
   assign o_mode_b              = {mode_r[1][1], mode_r[1][0]};

endmodule

// file: dhp_duart_port_map.svh
// offsets, field positions, reset values and timing counts of the host port
`ifndef DHP_DUART_PORT_MAP_SVH
`define DHP_DUART_PORT_MAP_SVH
`define DHP_OFS_MODE_A      4'h0
`define DHP_OFS_STAT_A      4'h1
`define DHP_OFS_CMD_A       4'h2
`define DHP_OFS_ISR         4'h3
`define DHP_OFS_IMR         4'h4
`define DHP_OFS_TEST        4'h5
`define DHP_OFS_MODE_B      4'h8
`define DHP_OFS_STAT_B      4'h9
`define DHP_OFS_CMD_B       4'ha
`define DHP_OFS_OUTPUT_PORT_CONFIG_REG        4'hb
`define DHP_OFS_IVR         4'hc
`define DHP_OFS_OPR_SET     4'hd
`define DHP_OFS_OPR_CLR     4'he
`define DHP_OFS_TMR_STOP    4'hf
`define DHP_CMD_ENABLE      0
`define DHP_CMD_DISABLE     1
`define DHP_CMD_PTR_RESET   2
`define DHP_IVR_RESET       8'h0f
`define DHP_ZERO_BYTE       8'h00
`define DHP_SYNC_STAGES     2
`endif

// file: dhp_pkg.sv
// types shared by the duart host bus port
package dhp_pkg;
   typedef logic [7:0] dhp_byte_t;
   typedef enum logic [1:0] {
      DHP_IDLE,
      DHP_ACCESS,
      DHP_ACK
   } dhp_state_e;
endpackage

// file: dhp_host_port_properties.sv
// concurrent checks on the host port pins
`timescale 1ns/100ps
module dhp_host_port_properties (
   input wire logic       i_clk,
   input wire logic       i_sys_rst,
   input wire logic       i_reset_low_input,
   input wire logic       i_chip_select_low,
   input wire logic       i_irq_ack_low,
   input wire logic       o_bus_data_oe,
   input wire logic       o_transfer_ack_low,
   input wire logic       o_transfer_ack_oe,
   input wire logic       o_irq_request_oe,
   input wire logic [7:0] o_general_output_pins,
   input wire logic [7:0] o_output_port_config,
   input wire logic       o_serial_out_chan_a,
   input wire logic [1:0] o_chan_active,
   input wire logic       o_timer_run,
   input wire logic [7:0] o_test_mode
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // margins cover the two synchroniser stages on the pins
   sequence s_cs_held;
      (!i_chip_select_low && i_irq_ack_low && i_reset_low_input)[*4];
   endsequence
   sequence s_iack_pend;
      (!i_irq_ack_low && i_chip_select_low && o_irq_request_oe && i_reset_low_input)[*4];
   endsequence
   a_data_release: assert property ( // bus released
      (i_chip_select_low && i_irq_ack_low)[*5] |-> !o_bus_data_oe)
      else $error("data bus driven while deselected");
   a_ack_cycle: assert property (s_cs_held |-> ##[0:3] o_transfer_ack_oe) // cycle acked
      else $error("no acknowledge in selected cycle");
   a_ack_level: assert property (o_transfer_ack_oe |-> !o_transfer_ack_low) // ack low
      else $error("acknowledge driven high");
   a_ack_origin: assert property ($rose(o_transfer_ack_oe) |-> // ack follows request
      $past(!i_chip_select_low || !i_irq_ack_low, 4))
      else $error("acknowledge without a request");
   a_vector_ack: assert property ( // vector acked
      s_iack_pend |-> ##[0:3] (o_transfer_ack_oe && o_bus_data_oe))
      else $error("pending acknowledge not answered");
   a_iack_idle: assert property ( // ack not driven
      (!i_irq_ack_low && i_chip_select_low && !o_irq_request_oe)[*8] |-> !o_transfer_ack_oe)
      else $error("acknowledge with nothing pending");
   a_sysrst_state: assert property ($fell(i_sys_rst) |-> o_general_output_pins == 8'hff
      && o_output_port_config == 8'h00 && !o_timer_run && o_test_mode == 8'h00)
      else $error("wrong state after reset");
   a_pinrst_state: assert property ((!i_reset_low_input)[*5] |-> !o_irq_request_oe
      && o_general_output_pins == 8'hff && o_chan_active == 2'b00 && o_serial_out_chan_a)
      else $error("reset pin effect missing");
   a_serial_mark: assert property ( // mark idle
      !o_chan_active[0] && $past(!o_chan_active[0]) |-> o_serial_out_chan_a)
      else $error("inactive channel not at mark");
endmodule
bind dhp_host_port dhp_host_port_properties u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_reset_low_input(i_reset_low_input), .i_chip_select_low(i_chip_select_low),
   .i_irq_ack_low(i_irq_ack_low), .o_bus_data_oe(o_bus_data_oe),
   .o_transfer_ack_low(o_transfer_ack_low), .o_transfer_ack_oe(o_transfer_ack_oe),
   .o_irq_request_oe(o_irq_request_oe), .o_general_output_pins(o_general_output_pins),
   .o_output_port_config(o_output_port_config), .o_serial_out_chan_a(o_serial_out_chan_a),
   .o_chan_active(o_chan_active), .o_timer_run(o_timer_run), .o_test_mode(o_test_mode));

// file: dhp_host_model.sv
// host processor model driving the port's bus pins
`timescale 1ns/100ps
module dhp_host_model (
   input  wire logic       i_clk,
   input  wire logic       i_ack_low,
   input  wire logic       i_ack_oe,
   input  wire logic [7:0] i_rdata,
   output logic            o_cs_low,
   output logic            o_rw,
   output logic [3:0]      o_sel,
   output logic [7:0]      o_wdata,
   output logic            o_iack_low
);
   initial
   begin
      {o_cs_low, o_rw, o_iack_low} = 3'b111;
      o_sel = 4'h0;
      o_wdata = 8'h00;
   end
   task automatic xfer(input logic iack, input logic rw, input logic [3:0] sel,
                       input logic [7:0] wd, output logic [7:0] rd, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      rd = 8'h00;
      @(posedge i_clk);
      #1;
      o_rw = rw;
      o_sel = sel;
      o_wdata = wd;
      if (iack)
         o_iack_low = 1'b0;
      else
         o_cs_low = 1'b0;
      while (!ok && n < 16)
      begin
         @(posedge i_clk);
         n++;
         if (i_ack_oe === 1'b1 && i_ack_low === 1'b0)
         begin
            ok = 1'b1;
            rd = i_rdata;
         end
      end
      #1;
      o_cs_low = 1'b1;
      o_iack_low = 1'b1;
      // released lines show inverted values, never a stale copy
      o_wdata = ~wd;
      o_sel = ~sel;
      repeat (5) @(posedge i_clk);
   endtask
endmodule

// file: test_dhp_host_port.sv
// self-checking bench for the duart host bus port
`timescale 1ns/100ps
module test_dhp_host_port;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        rst_low = 1'b1;
   logic [7:0]  ev = 8'h00;
   logic [7:0]  sta = 8'h00;
   logic [1:0]  tx = 2'b00;
   logic        cs_low, rw, iack_low, ack_low, ack_oe, doe, irq_oe, irql, sa, sb, run, ok;
   logic [3:0]  sel;
   logic [7:0]  wd, rd, dq, pins, cfg, tm;
   logic [15:0] ma, mb;
   logic [1:0]  act;
   int          err_total = 0;
   int          n_tests = 0;
   always #2 clk = ~clk;
   dhp_host_model dhp_host_model_i (.i_clk(clk), .i_ack_low(ack_low), .i_ack_oe(ack_oe),
      .i_rdata(dq), .o_cs_low(cs_low), .o_rw(rw), .o_sel(sel), .o_wdata(wd),
      .o_iack_low(iack_low));
   dhp_host_port dhp_host_port_i (.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
      .i_reset_low_input(rst_low), .i_chip_select_low(cs_low), .i_read_not_write_line(rw),
      .i_register_select_lines(sel), .i_bus_data_lines(wd), .i_irq_ack_low(iack_low),
      .i_irq_events(ev), .i_chan_a_status(sta), .i_chan_b_status(~sta), .i_tx_bit(tx),
      .o_bus_data_lines(dq), .o_bus_data_oe(doe), .o_transfer_ack_low(ack_low),
      .o_transfer_ack_oe(ack_oe), .o_irq_request_low(irql), .o_irq_request_oe(irq_oe),
      .o_general_output_pins(pins), .o_output_port_config(cfg), .o_serial_out_chan_a(sa),
      .o_serial_out_chan_b(sb), .o_chan_active(act), .o_timer_run(run), .o_test_mode(tm),
      .o_mode_a(ma), .o_mode_b(mb));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      dhp_host_model_i.xfer(1'b0, 1'b0, a, d, rd, ok);
      check(ok, 1'b1);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      dhp_host_model_i.xfer(1'b0, 1'b1, a, 8'h00, rd, ok);
      check({ok, rd}, {1'b1, e});
   endtask
   task automatic pulse(input logic [7:0] e);
      @(posedge clk) #1 ev = e;
      @(posedge clk) #1 ev = 8'h00;
      repeat (2) @(posedge clk);
   endtask
   task automatic complete_run;
      $display("checks=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #20000;
      err_total++;
      complete_run;
   end
   initial
   begin
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      check({pins, cfg}, 16'hff00);
      check({act, sa, sb, run, tm}, {2'b00, 3'b110, 8'h00});
      rdc(4'hc, 8'h0f);
      rdc(4'h0, 8'h00);
      wr(4'h0, 8'h3c);
      check(ma, 16'h3c00);
      wr(4'h2, 8'h04);
      wr(4'h0, 8'hc3);
      check(ma, 16'h3cc3);
      wr(4'hc, 8'h35);
      rdc(4'hc, 8'h35);
      check(doe, 1'b0);
      wr(4'h5, 8'h5a);
      check(tm, 8'h5a);
      rdc(4'h6, 8'h00);
      wr(4'hd, 8'h81);
      check(pins, 8'h7e);
      wr(4'he, 8'h01);
      check(pins, 8'h7f);
      wr(4'hb, 8'h12);
      check(cfg, 8'h12);
      #1 sta = 8'h96;
      rdc(4'h1, 8'h96);
      wr(4'h2, 8'h01);
      wr(4'ha, 8'h01);
      check({act, sa, sb}, 4'b1100);
      wr(4'ha, 8'h03);
      check({act, sa, sb}, 4'b0101);
      wr(4'h4, 8'h01);
      pulse(8'h01);
      check({irq_oe, irql}, 2'b10);
      dhp_host_model_i.xfer(1'b1, 1'b1, 4'h0, 8'h00, rd, ok);
      check({ok, rd}, {1'b1, 8'h35});
      wr(4'h3, 8'h01);
      check(irq_oe, 1'b0);
      dhp_host_model_i.xfer(1'b1, 1'b1, 4'h0, 8'h00, rd, ok);
      check({ok, doe}, 2'b00);
      wr(4'h4, 8'hfd);
      pulse(8'h02);
      check(irq_oe, 1'b0);
      rdc(4'he, 8'h00);
      check(run, 1'b1);
      @(posedge clk) #1 rst_low = 1'b0;
      repeat (6) @(posedge clk);
      check({pins, cfg}, 16'hff00);
      check({act, sa, sb, run, tm}, {2'b00, 3'b110, 8'h00});
      #1 rst_low = 1'b1;
      repeat (3) @(posedge clk);
      rdc(4'hc, 8'h0f);
      rdc(4'h4, 8'h00);
      rdc(4'h3, 8'h00);
      wr(4'h0, 8'ha5);
      check(ma[7:0], 8'ha5);
      wr(4'h8, 8'h77);
      check(mb[7:0], 8'h77);
      complete_run;
   end
endmodule
